// ==== pkg/mshb_defs.svh ====
// Constants for the microsequencer and host bus interface
`ifndef MSHB_DEFS_SVH
`define MSHB_DEFS_SVH
`define MSHB_MI_COND_BIT 27
`define MSHB_MI_POL_BIT 26
`define MSHB_MI_DBT_BIT 25
`define MSHB_MI_TSEL_LO 28
`define MSHB_MI_OP_LO 0
`define MSHB_MI_LIT_BIT 24
`define MSHB_INT_BASE 10'h0300
`define MSHB_PIO_BASE 10'h03f0
`define MSHB_ST_PASS 5'h00
`define MSHB_ST_PUP 5'h18
`define MSHB_ST_RFS 5'h10
`define MSHB_ST_STEPS 3
`define MSHB_PC_RESET 10'h0000
`endif

// ==== pkg/mshb_pkg.sv ====
// Types for the microsequencer and host bus interface
`default_nettype none
package mshb_pkg;
  typedef enum logic [3:0] {
    MSHB_OP_JZ = 4'h0, MSHB_OP_CJS = 4'h1, MSHB_OP_JMAP = 4'h2,
    MSHB_OP_CJP = 4'h3, MSHB_OP_PUSH = 4'h4, MSHB_OP_JSRP = 4'h5,
    MSHB_OP_CJV = 4'h6, MSHB_OP_JRP = 4'h7, MSHB_OP_RFCT = 4'h8,
    MSHB_OP_RPCT = 4'h9, MSHB_OP_CRTN = 4'ha, MSHB_OP_CJPP = 4'hb,
    MSHB_OP_LDCT = 4'hc, MSHB_OP_LOOP = 4'hd, MSHB_OP_CONT = 4'he,
    MSHB_OP_TWB = 4'hf
  } mshb_op_t;
  typedef enum logic [5:0] {
    MSHB_BS_IDLE = 6'b000001, MSHB_BS_WAIT = 6'b000010,
    MSHB_BS_ADDR = 6'b000100, MSHB_BS_DATA = 6'b001000,
    MSHB_BS_RDWT = 6'b010000, MSHB_BS_DONE = 6'b100000
  } mshb_bus_t;
endpackage : mshb_pkg
`default_nettype wire

// ==== rtl/mshb_core.sv ====
// Microprogram address selection and host bus sequencer
// Summary of operation
// - Address from sequencer, I/O vector or file
// - Sequencer sources: direct, counter, stack, register
// - Opcode shares literal bits; literal allows continue/return
// - Bit 27 conditional, bit 26 test sense
// - Bit 25 picks bus bit; 28-31 select
// - Five interrupts, 8-bit vectors, range 300-3FF
// - Programmed-I/O entries only 3F0 to 3FF
// - Address detect interrupts when enabled and prioritised
// - Four programmable 8-bit vector file entries
// - Receive latches transparent, address watched continuously
// - Driver register loaded from internal data bus
// - Addressed on sync edge: bank7, A04, switches
// - A01-A03 pick register, A00 picks byte
// - Reads taken before deselect vector 3F8-3FF; writes and late reads 3F0-3F7
// - Byte writes gate clock of addressed byte
// - DMA request and direction are firmware latches
// - Grant taken, bus mastered, address interrupt raised
// - Write: load data, clear request, cycle ends
// - Read: interrupt on data, clear ends operation
// - Host interrupt only with command enable set
// - Interrupt latch acquires bus, vector, then clear
// - Self-test codes shown on LEDs, 00 passes
`include "mshb_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module mshb_core
  import mshb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Microinstruction and sequencer inputs
  input wire logic [31:0] microinstruction_bit,
  input wire logic [15:0] internal_data_bus,
  input wire logic [15:0] cond_codes,
  input wire logic uint_enable,
  input wire logic [3:0] uint_src_req,
  // Firmware controls
  input wire logic vfile_we,
  input wire logic [1:0] vfile_sel,
  input wire logic drv_load,
  input wire logic dma_req_set,
  input wire logic dma_req_clr,
  input wire logic dir_set,
  input wire logic dir_clr,
  input wire logic irq_set,
  input wire logic irq_clr,
  input wire logic cmd_int_enable,
  input wire logic [7:0] addr_switch,
  input wire logic [4:0] selftest_code,
  input wire logic selftest_load,
  // Host bus pins
  input wire logic [15:0] bus_dal_in,
  input wire logic bus_sync,
  input wire logic bus_din,
  input wire logic bus_dout,
  input wire logic bus_bs7,
  input wire logic bus_wtbt,
  input wire logic bus_dma_grant,
  input wire logic bus_iak,
  input wire logic bus_reply_in,
  output logic [15:0] bus_dal_out,
  output logic bus_dal_oe,
  output logic bus_dma_req,
  output logic bus_irq,
  output logic bus_sack,
  output logic bus_sync_out,
  output logic bus_wtbt_out,
  // Internal results
  output logic [9:0] uaddr,
  output logic [15:0] rx_data,
  output logic [1:0] byte_clk_en,
  output logic transfer_direction_latch,
  output logic [4:0] led_code
);
  // ==========================================
  // Pin synchronisers
  logic [15:0] dal_s1_reg, dal_s2_reg;
  logic [8:0] ctl_s1_reg, ctl_s2_reg;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dal_s1_reg <= 16'h0000;
      dal_s2_reg <= 16'h0000;
      ctl_s1_reg <= 9'h000;
      ctl_s2_reg <= 9'h000;
    end else begin
      dal_s1_reg <= bus_dal_in;
      dal_s2_reg <= dal_s1_reg;
      ctl_s1_reg <= {bus_reply_in, bus_iak, bus_dma_grant, bus_wtbt,
                     bus_bs7, bus_dout, bus_din, bus_sync, 1'b0};
      ctl_s2_reg <= ctl_s1_reg;
    end
  end
  wire sync_s = ctl_s2_reg[1];
  wire din_s = ctl_s2_reg[2];
  wire dout_s = ctl_s2_reg[3];
  wire bs7_s = ctl_s2_reg[4];
  wire wtbt_s = ctl_s2_reg[5];
  wire grant_s = ctl_s2_reg[6];
  wire iak_s = ctl_s2_reg[7];
  wire reply_s = ctl_s2_reg[8];
  // ==========================================
  // Address recognition
  logic sync_d_reg, sel_reg, sel_dir_reg;
  logic [2:0] sel_regno_reg;
  logic sel_byte_reg, pio_pend_reg;
  // One interrupt per selected bus cycle
  logic pio_seen_reg;
  wire sync_rise = sync_s & ~sync_d_reg;
  wire addr_hit = sync_rise & bs7_s & dal_s2_reg[4] &
                  (dal_s2_reg[12:5] == addr_switch);
  assign rx_data = dal_s2_reg;
  // Priority grant and address mux
  wire boundary = 1'b1;
  wire pio_take = pio_pend_reg & uint_enable & boundary;
  // Sequencer interrupt sources: bus events plus external sources
  logic bs_int_reg;
  wire [3:0] int_req = {uint_src_req[3:1], uint_src_req[0] | bs_int_reg};
  logic [3:0] vf_take;
  logic [7:0] vfile [0:3];
  wire [9:0] pio_vec = `MSHB_PIO_BASE |
                       {6'h00, sel_dir_reg, sel_regno_reg};
  logic [9:0] vf_vec;
  logic vf_any;
  always_comb begin
    vf_take = 4'h0;
    vf_vec = `MSHB_INT_BASE;
    vf_any = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!vf_any && !pio_pend_reg && uint_enable && int_req[i]) begin
        vf_take[i] = 1'b1;
        vf_vec = `MSHB_INT_BASE | {2'b00, vfile[i]};
        vf_any = 1'b1;
      end
    end
  end
  // ==========================================
  // Sequencer
  logic [9:0] upc_reg, rc_reg;
  logic [9:0] stack [0:4];
  logic [2:0] sp_reg;
  wire [3:0] opcode = microinstruction_bit[3:0];
  wire lit_on = microinstruction_bit[`MSHB_MI_LIT_BIT];
  wire [9:0] dfield = microinstruction_bit[13:4];
  wire [3:0] tsel = microinstruction_bit[31:28];
  wire test_raw = microinstruction_bit[`MSHB_MI_DBT_BIT] ?
                  internal_data_bus[tsel] : cond_codes[tsel];
  wire test_ok = ~microinstruction_bit[`MSHB_MI_COND_BIT] |
                 (test_raw ^ microinstruction_bit[`MSHB_MI_POL_BIT]);
  wire [3:0] op_eff = (lit_on && opcode != MSHB_OP_CRTN) ?
                      MSHB_OP_CONT : opcode;
  wire [9:0] tos = stack[sp_reg == 3'd0 ? 3'd0 : sp_reg - 3'd1];
  logic [9:0] seq_addr;
  always_comb begin
    unique case (op_eff)
      MSHB_OP_JZ: seq_addr = 10'h000;
      MSHB_OP_CJS, MSHB_OP_CJP, MSHB_OP_JMAP, MSHB_OP_CJV:
        seq_addr = test_ok ? dfield : upc_reg;
      MSHB_OP_JSRP, MSHB_OP_JRP: seq_addr = test_ok ? dfield : rc_reg;
      MSHB_OP_CRTN, MSHB_OP_RFCT, MSHB_OP_LOOP:
        seq_addr = (op_eff == MSHB_OP_CRTN ? test_ok :
                    (op_eff == MSHB_OP_LOOP ? ~test_ok : rc_reg != 0))
                   ? tos : upc_reg;
      MSHB_OP_RPCT: seq_addr = (rc_reg != 0) ? dfield : upc_reg;
      MSHB_OP_TWB: seq_addr = test_ok ? upc_reg : tos;
      default: seq_addr = upc_reg;
    endcase
  end
  wire [9:0] addr_next = pio_take ? pio_vec :
                         (vf_any ? vf_vec : seq_addr);
  wire push = (op_eff == MSHB_OP_PUSH) || (op_eff == MSHB_OP_CJS && test_ok);
  wire pop = (op_eff == MSHB_OP_CRTN && test_ok) ||
             (op_eff == MSHB_OP_LOOP && test_ok);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      upc_reg <= `MSHB_PC_RESET;
      rc_reg <= 10'h000;
      sp_reg <= 3'd0;
      uaddr <= `MSHB_PC_RESET;
    end else begin
      uaddr <= addr_next;
      upc_reg <= addr_next + 10'h001;
      if (op_eff == MSHB_OP_LDCT || (op_eff == MSHB_OP_PUSH && test_ok))
        rc_reg <= dfield;
      else if ((op_eff == MSHB_OP_RFCT || op_eff == MSHB_OP_RPCT) &&
               rc_reg != 0)
        rc_reg <= rc_reg - 10'h001;
      if (push && sp_reg != 3'd5) sp_reg <= sp_reg + 3'd1;
      else if (pop && sp_reg != 3'd0) sp_reg <= sp_reg - 3'd1;
    end
  end
  always_ff @(posedge mclk) begin
    if (push && sp_reg != 3'd5) stack[sp_reg] <= upc_reg;
    if (vfile_we) vfile[vfile_sel] <= internal_data_bus[7:0];
  end
  // ==========================================
  // Firmware latches and bus sequencer
  logic dma_request_latch_reg, irqr_reg;
  logic [15:0] drv_reg;
  mshb_bus_t bs_reg, bs_next;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync_d_reg <= 1'b0;
      sel_reg <= 1'b0;
      sel_dir_reg <= 1'b0;
      sel_regno_reg <= 3'd0;
      sel_byte_reg <= 1'b0;
      pio_pend_reg <= 1'b0;
      pio_seen_reg <= 1'b0;
      dma_request_latch_reg <= 1'b0;
      irqr_reg <= 1'b0;
      transfer_direction_latch <= 1'b0;
      drv_reg <= 16'h0000;
    end else begin
      sync_d_reg <= sync_s;
      if (addr_hit) begin
        sel_regno_reg <= dal_s2_reg[3:1];
        sel_byte_reg <= dal_s2_reg[0];
        sel_reg <= 1'b1;
      end else if (!sync_s) sel_reg <= 1'b0;
      if (sel_reg && (din_s || dout_s) && !pio_seen_reg) begin
        pio_pend_reg <= 1'b1;
        pio_seen_reg <= 1'b1;
        sel_dir_reg <= din_s;
      end else if (pio_take) pio_pend_reg <= 1'b0;
      if (!sel_reg) begin
        sel_dir_reg <= 1'b0;
        pio_seen_reg <= 1'b0;
      end
      if (dma_req_set) dma_request_latch_reg <= 1'b1;
      else if (dma_req_clr) dma_request_latch_reg <= 1'b0;
      if (dir_set) transfer_direction_latch <= 1'b1;
      else if (dir_clr) transfer_direction_latch <= 1'b0;
      if (irq_set && cmd_int_enable) irqr_reg <= 1'b1;
      else if (irq_clr) irqr_reg <= 1'b0;
      if (drv_load) drv_reg <= internal_data_bus;
    end
  end
  always_comb begin
    bs_next = bs_reg;
    unique case (bs_reg)
      MSHB_BS_IDLE: if (dma_request_latch_reg || irqr_reg) bs_next = MSHB_BS_WAIT;
      MSHB_BS_WAIT: if (grant_s || iak_s) bs_next = MSHB_BS_ADDR;
      MSHB_BS_ADDR: if (drv_load) bs_next = dma_request_latch_reg && !irqr_reg &&
                          !transfer_direction_latch ?
                          MSHB_BS_RDWT : MSHB_BS_DATA;
      MSHB_BS_RDWT: if (reply_s) bs_next = MSHB_BS_DATA;
      MSHB_BS_DATA: if (!dma_request_latch_reg && !irqr_reg) bs_next = MSHB_BS_DONE;
      MSHB_BS_DONE: bs_next = MSHB_BS_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bs_reg <= MSHB_BS_IDLE;
      bs_int_reg <= 1'b0;
      bus_dal_out <= 16'h0000;
      bus_dal_oe <= 1'b0;
      bus_dma_req <= 1'b0;
      bus_irq <= 1'b0;
      bus_sack <= 1'b0;
      bus_sync_out <= 1'b0;
      bus_wtbt_out <= 1'b0;
      byte_clk_en <= 2'b00;
      led_code <= `MSHB_ST_PUP;
    end else begin
      bs_reg <= bs_next;
      bs_int_reg <= (bs_reg == MSHB_BS_WAIT && bs_next == MSHB_BS_ADDR) ||
                    (bs_reg == MSHB_BS_RDWT && reply_s);
      bus_dal_out <= drv_reg;
      bus_dal_oe <= (bs_reg != MSHB_BS_IDLE && bs_reg != MSHB_BS_WAIT &&
                     bs_reg != MSHB_BS_RDWT) || (sel_reg && din_s);
      bus_dma_req <= dma_request_latch_reg && bs_reg == MSHB_BS_WAIT;
      bus_irq <= irqr_reg && bs_reg == MSHB_BS_WAIT;
      bus_sack <= bs_reg != MSHB_BS_IDLE && bs_reg != MSHB_BS_WAIT;
      bus_sync_out <= bs_reg == MSHB_BS_DATA || bs_reg == MSHB_BS_RDWT;
      bus_wtbt_out <= transfer_direction_latch;
      byte_clk_en <= (sel_reg && dout_s) ? (wtbt_s ?
                     (sel_byte_reg ? 2'b10 : 2'b01) : 2'b11) : 2'b00;
      if (selftest_load) led_code <= selftest_code;
    end
  end
  // ==========================================
  // Checks
  chk_vec_range: assert property (@(posedge mclk) disable iff (reset)
    $past(pio_take) |-> uaddr[9:4] == 6'h3f)
    else $error("Programmed I/O vector out of range");
  chk_vf_range: assert property (@(posedge mclk) disable iff (reset)
    ($past(vf_any) && !$past(pio_take)) |-> uaddr[9:8] == 2'b11)
    else $error("Vector file entry out of range");
  chk_irq_gate: assert property (@(posedge mclk) disable iff (reset)
    (irq_set && !cmd_int_enable && !irqr_reg) |=> !irqr_reg)
    else $error("Interrupt latched without enable");
  chk_dma_latch: assert property (@(posedge mclk) disable iff (reset)
    dma_req_set |=> dma_request_latch_reg)
    else $error("DMA request latch not set");
  chk_dma_grant: assert property (@(posedge mclk) disable iff (reset)
    (bs_reg == MSHB_BS_WAIT && grant_s) |=> bs_int_reg)
    else $error("No interrupt after grant");
  chk_dma_end: assert property (@(posedge mclk) disable iff (reset)
    (bs_reg == MSHB_BS_DATA && !dma_request_latch_reg && !irqr_reg) |=>
    bs_reg == MSHB_BS_DONE ##1 bs_reg == MSHB_BS_IDLE)
    else $error("Bus cycle not finished after clear");
  chk_pio_prio: assert property (@(posedge mclk) disable iff (reset)
    (pio_pend_reg && uint_enable) |=> uaddr[9:4] == 6'h3f)
    else $error("Address interrupt lost priority");
  chk_cond_sense: assert property (@(posedge mclk) disable iff (reset)
    (!microinstruction_bit[27] && !lit_on && opcode == MSHB_OP_CJP &&
     !pio_take && !vf_any) |=> uaddr == $past(dfield))
    else $error("Unconditional jump not taken");
  // Sequencer checks
  chk_lit_cont: assert property (
    @(posedge mclk) disable iff (reset)
    (lit_on && opcode != MSHB_OP_CRTN && !pio_take && !vf_any) |=>
    uaddr == $past(upc_reg))
    else $error("Literal word did not continue");
  chk_data_bus_bit_test: assert property (
    @(posedge mclk) disable iff (reset)
    (microinstruction_bit[27] && microinstruction_bit[25] &&
     !microinstruction_bit[26] && !lit_on && opcode == MSHB_OP_CJP &&
     internal_data_bus[tsel] && !pio_take && !vf_any) |=>
    uaddr == $past(dfield))
    else $error("Bus bit test branch not taken");
  chk_stack_bound: assert property (
    @(posedge mclk) disable iff (reset)
    sp_reg <= 3'd5)
    else $error("Stack pointer out of range");
  // Interrupt vector and address match checks
  chk_pio_dir: assert property (
    @(posedge mclk) disable iff (reset)
    (pio_take && sel_dir_reg) |=> uaddr[3])
    else $error("Read access vectored to write entry");
  chk_addr_sel: assert property (
    @(posedge mclk) disable iff (reset)
    addr_hit |=> sel_reg)
    else $error("Address match not selected");
  chk_vf_first: assert property (
    @(posedge mclk) disable iff (reset)
    (uint_enable && !pio_pend_reg && int_req[0]) |=>
    uaddr == {2'b11, $past(vfile[0])})
    else $error("Highest source not served first");
  chk_one_src: assert property (
    @(posedge mclk) disable iff (reset)
    $onehot0(vf_take))
    else $error("Two vector sources served at once");
  // Host bus and self-test display checks
  chk_drv_out: assert property (
    @(posedge mclk) disable iff (reset)
    drv_load |=> ##1 bus_dal_out == $past(internal_data_bus, 2))
    else $error("Driver register not on bus");
  chk_iak_int: assert property (
    @(posedge mclk) disable iff (reset)
    (bs_reg == MSHB_BS_WAIT && iak_s) |=> bs_int_reg)
    else $error("No interrupt after acknowledge");
  chk_reply_int: assert property (
    @(posedge mclk) disable iff (reset)
    (bs_reg == MSHB_BS_RDWT && reply_s) |=>
    (bs_int_reg && bs_reg == MSHB_BS_DATA))
    else $error("No interrupt after memory reply");
  chk_byte_gate: assert property (
    @(posedge mclk) disable iff (reset)
    byte_clk_en != 2'b00 |-> $past(sel_reg && dout_s))
    else $error("Byte clock without host write");
  chk_irq_out: assert property (
    @(posedge mclk) disable iff (reset)
    bus_irq |-> $past(irqr_reg))
    else $error("Bus interrupt without latch");
  chk_dma_out: assert property (
    @(posedge mclk) disable iff (reset)
    bus_dma_req |-> $past(dma_request_latch_reg))
    else $error("Bus DMA request without latch");
  chk_wtbt_out: assert property (
    @(posedge mclk) disable iff (reset)
    bus_wtbt_out == $past(transfer_direction_latch))
    else $error("Write byte pin does not follow latch");
  chk_dir_set: assert property (
    @(posedge mclk) disable iff (reset)
    dir_set |=> transfer_direction_latch)
    else $error("Direction latch not set");
  chk_led_load: assert property (
    @(posedge mclk) disable iff (reset)
    selftest_load |=> led_code == $past(selftest_code))
    else $error("Self-test code not shown");
endmodule : mshb_core
`default_nettype wire

// ==== tb/mshb_host_model.sv ====
// Host processor and memory model on the multiplexed bus
`timescale 1ns/1ns
`default_nettype none
module mshb_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // From the device
  input wire logic bus_dma_req,
  input wire logic bus_irq,
  input wire logic bus_sync_out,
  input wire logic [15:0] reply_word,
  // To the device
  output logic [15:0] bus_dal_in,
  output logic bus_sync,
  output logic bus_din,
  output logic bus_dout,
  output logic bus_bs7,
  output logic bus_wtbt,
  output logic bus_dma_grant,
  output logic bus_iak,
  output logic bus_reply_in
);
  logic [15:0] dal_reg = 16'h0000;
  logic dal_on = 1'b0;
  // Released lines show the reply word during a reply, else the inverse of their last value
  assign bus_dal_in = dal_on ? dal_reg :
                      bus_reply_in ? reply_word : ~dal_reg;
  initial begin
    {bus_sync, bus_din, bus_dout, bus_bs7, bus_wtbt} = 5'h00;
  end
  // =========================
  // Grant, acknowledge and reply one cycle after the device asks
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_dma_grant <= 1'b0;
      bus_iak <= 1'b0;
      bus_reply_in <= 1'b0;
    end else begin
      bus_dma_grant <= bus_dma_req;
      bus_iak <= bus_irq;
      bus_reply_in <= bus_sync_out;
    end
  end
  // =========================
  // Programmed access: address phase, then data phase
  task automatic host_cycle(input logic [15:0] a, input logic rd,
      input logic bt, input logic bs);
    @(negedge mclk);
    dal_reg = a;
    dal_on = 1'b1;
    bus_bs7 = bs;
    bus_wtbt = bt;
    @(negedge mclk);
    bus_sync = 1'b1;
    repeat (5) @(negedge mclk);
    dal_reg = 16'h00a5;
    bus_din = rd;
    bus_dout = !rd;
    repeat (8) @(negedge mclk);
    {bus_sync, bus_din, bus_dout, bus_bs7, bus_wtbt, dal_on} = 6'h00;
  endtask : host_cycle
endmodule : mshb_host_model
`default_nettype wire

// ==== tb/mshb_core_test.sv ====
// Self-checking bench for the microsequencer and host bus interface
`timescale 1ns/1ns
`default_nettype none
module mshb_core_test
  import mshb_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] microinstruction_bit = 32'h0000_0000;
  logic [15:0] internal_data_bus = 16'h0000, cond_codes = 16'h0000;
  logic [15:0] reply_word = 16'h0000, bus_dal_in, bus_dal_out, rx_data;
  logic [3:0] uint_src_req = 4'h0;
  logic [1:0] vfile_sel = 2'h0, byte_clk_en, bce_seen;
  logic [7:0] addr_switch = 8'h5a;
  logic [4:0] selftest_code = 5'h00, led_code;
  logic [9:0] uaddr;
  logic uint_enable = 1'b0, vfile_we = 1'b0, drv_load = 1'b0;
  logic dma_req_set = 1'b0, dma_req_clr = 1'b0, dir_set = 1'b0;
  logic dir_clr = 1'b0, irq_set = 1'b0, irq_clr = 1'b0;
  logic cmd_int_enable = 1'b0, selftest_load = 1'b0, hi_seen;
  logic bus_sync, bus_din, bus_dout, bus_bs7, bus_wtbt, bus_dma_grant;
  logic bus_iak, bus_reply_in, bus_dal_oe, bus_dma_req, bus_irq, bus_sack;
  logic bus_sync_out, bus_wtbt_out, transfer_direction_latch;
  logic [16:0] neg_tbl [3] = '{17'h1_0b7c, 17'h1_0b4c, 17'h0_0b5c};
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  mshb_core dut_u (
    .mclk, .reset, .microinstruction_bit, .internal_data_bus, .cond_codes,
    .uint_enable, .uint_src_req, .vfile_we, .vfile_sel, .drv_load,
    .dma_req_set, .dma_req_clr, .dir_set, .dir_clr, .irq_set, .irq_clr,
    .cmd_int_enable, .addr_switch, .selftest_code, .selftest_load,
    .bus_dal_in, .bus_sync, .bus_din, .bus_dout, .bus_bs7, .bus_wtbt,
    .bus_dma_grant, .bus_iak, .bus_reply_in, .bus_dal_out, .bus_dal_oe,
    .bus_dma_req, .bus_irq, .bus_sack, .bus_sync_out, .bus_wtbt_out,
    .uaddr, .rx_data, .byte_clk_en, .transfer_direction_latch, .led_code
  );
  mshb_host_model host_u (
    .mclk, .reset, .bus_dma_req, .bus_irq, .bus_sync_out, .reply_word,
    .bus_dal_in, .bus_sync, .bus_din, .bus_dout, .bus_bs7, .bus_wtbt,
    .bus_dma_grant, .bus_iak, .bus_reply_in
  );
  // =========================
  // Clock, watchdog and sticky observers
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (byte_clk_en !== 2'h0) bce_seen <= byte_clk_en;
    if (uaddr[9:8] === 2'h3) hi_seen <= 1'b1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic check(input string n, input logic [15:0] s,
      input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // =========================
  // Helpers
  function automatic logic [31:0] mi(input mshb_op_t op,
      input logic [9:0] d, input logic [7:0] f);
    return {f, 10'h000, d, op};
  endfunction : mi
  task automatic step(input logic [31:0] w, input logic [9:0] e);
    microinstruction_bit = w;
    @(negedge mclk);
    check("uaddr", {6'h00, uaddr}, {6'h00, e});
  endtask : step
  task automatic wait_ua(input logic [9:0] e);
    repeat (40) if (uaddr !== e) @(negedge mclk);
    check("uaddr", {6'h00, uaddr}, {6'h00, e});
  endtask : wait_ua
  task automatic vfile_write(input logic [1:0] s, input logic [7:0] v);
    vfile_sel = s;
    internal_data_bus = {8'h00, v};
    vfile_we = 1'b1;
    @(negedge mclk);
    vfile_we = 1'b0;
  endtask : vfile_write
  task automatic load(input logic [15:0] v);
    internal_data_bus = v;
    drv_load = 1'b1;
    @(negedge mclk);
    drv_load = 1'b0;
    @(negedge mclk);
    check("dal out", bus_dal_out, v);
  endtask : load
  // =========================
  // Scenarios
  task automatic t_seq();
    check("led", {11'h000, led_code}, 16'h0018);
    check("bus outs", {bus_dma_req, bus_irq, bus_dal_oe, 13'h0000}, 0);
    step(mi(MSHB_OP_JZ, 10'h000, 8'h00), 10'h000);
    step(mi(MSHB_OP_CJP, 10'h123, 8'h00), 10'h123);
    step(mi(MSHB_OP_CONT, 10'h3ff, 8'h00), 10'h124);
    cond_codes = 16'h0020;
    step(mi(MSHB_OP_CJP, 10'h0ab, 8'h58), 10'h0ab);
    step(mi(MSHB_OP_CJP, 10'h1ff, 8'h5c), 10'h0ac);
    internal_data_bus = 16'h0008;
    step(mi(MSHB_OP_CJP, 10'h2a0, 8'h3a), 10'h2a0);
    step(mi(MSHB_OP_CJP, 10'h111, 8'h01), 10'h2a1);
    step(mi(MSHB_OP_CJS, 10'h050, 8'h00), 10'h050);
    step(mi(MSHB_OP_CRTN, 10'h000, 8'h01), 10'h2a2);
    step(32'h0000_0000, 10'h000);
    $display("sequencer test done");
  endtask : t_seq
  task automatic t_vfile();
    vfile_write(2'h1, 8'h4c);
    vfile_write(2'h2, 8'h91);
    uint_enable = 1'b1;
    uint_src_req = 4'h6;
    wait_ua(10'h34c);
    uint_src_req = 4'h4;
    @(negedge mclk);
    wait_ua(10'h391);
    uint_enable = 1'b0;
    repeat (3) @(negedge mclk);
    check("masked", {6'h00, uaddr}, 16'h0000);
    uint_src_req = 4'h0;
    uint_enable = 1'b1;
    $display("vector file test done");
  endtask : t_vfile
  task automatic t_prog();
    fork
      host_u.host_cycle(16'h0b5c, 1'b1, 1'b0, 1'b1);
      wait_ua(10'h3fe);
    join
    bce_seen = 2'h0;
    fork
      host_u.host_cycle(16'h0b55, 1'b0, 1'b1, 1'b1);
      wait_ua(10'h3f2);
    join
    check("byte clk", {14'h0000, bce_seen}, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      hi_seen = 1'b0;
      host_u.host_cycle(neg_tbl[i][15:0], 1'b1, 1'b0, neg_tbl[i][16]);
      repeat (5) @(negedge mclk);
      check("stray int", {15'h0000, hi_seen}, 16'h0000);
    end
    $display("programmed access test done");
  endtask : t_prog
  task automatic t_dma(input logic d);
    vfile_write(2'h0, 8'h20);
    reply_word = 16'hbeef;
    dir_set = d;
    dir_clr = !d;
    @(negedge mclk);
    {dir_set, dir_clr} = 2'h0;
    @(negedge mclk);
    check("dir", {15'h0000, transfer_direction_latch}, {15'h0000, d});
    dma_req_set = 1'b1;
    @(negedge mclk);
    dma_req_set = 1'b0;
    repeat (20) if (bus_dma_req !== 1'b1) @(negedge mclk);
    check("dma req", {15'h0000, bus_dma_req}, 16'h0001);
    wait_ua(10'h320);
    load(16'h1234);
    if (d) begin
      load(16'h5678);
    end else begin
      wait_ua(10'h000);
      wait_ua(10'h320);
      check("rx data", rx_data, 16'hbeef);
    end
    dma_req_clr = 1'b1;
    @(negedge mclk);
    dma_req_clr = 1'b0;
    repeat (20) if (bus_dma_req !== 1'b0) @(negedge mclk);
    check("dma end", {15'h0000, bus_dma_req}, 16'h0000);
    $display("dma test done");
  endtask : t_dma
  task automatic t_irq(input logic en);
    cmd_int_enable = en;
    irq_set = 1'b1;
    @(negedge mclk);
    irq_set = 1'b0;
    repeat (8) if (bus_irq !== en) @(negedge mclk);
    check("irq", {15'h0000, bus_irq}, {15'h0000, en});
    if (en) begin
      wait_ua(10'h320);
      load(16'h00a0);
      irq_clr = 1'b1;
      @(negedge mclk);
      irq_clr = 1'b0;
      repeat (20) if (bus_irq !== 1'b0) @(negedge mclk);
      check("irq end", {15'h0000, bus_irq}, 16'h0000);
    end
    $display("interrupt request test done");
  endtask : t_irq
  task automatic t_led(input logic [4:0] c);
    selftest_code = c;
    selftest_load = 1'b1;
    @(negedge mclk);
    selftest_load = 1'b0;
    @(negedge mclk);
    check("led", {11'h000, led_code}, {11'h000, c});
    $display("self-test display test done");
  endtask : t_led
  initial begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    t_seq();
    t_vfile();
    t_prog();
    t_dma(1'b0);
    t_dma(1'b1);
    t_irq(1'b0);
    t_irq(1'b1);
    t_led(5'h10);
    t_led(5'h00);
    close_out();
  end
endmodule : mshb_core_test
`default_nettype wire
